// [bench/scsi_transfer_signal_control_tb.sv]
// testbench: register bank, bus line drive, timer and data path of stc_ctrl
module scsi_transfer_signal_control_tb;
  import stc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [16:0] TICK = 17'h00004;
  logic mclk = 0, sysRst = 1, busRstIn = 1, selSeqStart = 0, selSeqActive = 0;
  logic bsyReturned = 0, cntWrapEvt = 0, inboundValid = 0, parityErrIn = 0;
  logic [7:0] fifoRdData = 8'h00, peerOe = 8'h00, busIn, rd, oe, txData, drv;
  logic fifoWrEn, discardActive, alignHandshake, cntStopAtZero, asyncMode, err;
  logic [3:0] per, ofs;
  logic [1:0] pw;
  stc_apb_req_t req = '0;
  stc_apb_rsp_t rsp;
  int numErrors = 0, samplesChecked = 0, cyc = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  stc_bus_peer peer (.devOe(oe), .peerOe(peerOe), .busLines(busIn));
  stc_ctrl #(.TICK_CYCLES(TICK)) dut (.mclk(mclk), .sys_rst(sysRst), .apbReq(req),
    .apbRsp(rsp), .busLinesIn(busIn), .busLinesOut(drv), .busLinesOe(oe), .busRstIn(busRstIn),
    .selSeqStart(selSeqStart), .selSeqActive(selSeqActive), .bsyReturned(bsyReturned),
    .cntWrapEvt(cntWrapEvt), .cntStopAtZero(cntStopAtZero), .inboundValid(inboundValid),
    .fifoWrEn(fifoWrEn), .fifoRdData(fifoRdData), .txData(txData),
    .discardActive(discardActive), .alignHandshake(alignHandshake), .parityErrIn(parityErrIn),
    .syncPeriodCycles(per), .syncPulseCycles(pw), .syncOffset(ofs), .asyncMode(asyncMode));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finalReport();
    $display("errors %0d, checks %0d", numErrors, samplesChecked);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= wr;
    req.paddr <= {idx, 2'b00}; req.pwdata <= {24'h000000, wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0; req.penable <= 1'b0;
    if (n >= 50) begin
      chk("pready", 9'h001, 9'h000);
      finalReport();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic regScenario();
    apb(0, IDX_XFER_CTL, 0); chk("xfer reset", 9'h000, {1'b0, rd});
    apb(1, IDX_XFER_CTL, 8'hFF); apb(0, IDX_XFER_CTL, 0);
    chk("xfer readback", 9'h0FE, {1'b0, rd});
    apb(1, IDX_XFER_CTL, 8'h02); @(negedge mclk);
    chk("align pulse", 9'h001, {8'h00, alignHandshake});
    @(negedge mclk); chk("align end", 9'h000, {8'h00, alignHandshake});
    apb(0, 10'h100, 0); chk("unmapped", 9'h100, {err, rd});
  endtask
  task automatic dataScenario();
    // initiator discards the bits; target ignores discard
    apb(1, IDX_MODE, 8'h00); apb(1, IDX_XFER_CTL, 8'h80);
    @(posedge mclk); fifoRdData <= 8'h5A; inboundValid <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("discard", 9'h100, {discardActive, fifoWrEn, txData[6:0]});
    apb(1, IDX_MODE, 8'h01); repeat (2) @(negedge mclk);
    chk("no discard", 9'h05A, {discardActive, txData});
    chk("fifo write", 9'h001, {8'h00, fifoWrEn});
  endtask
  task automatic statusScenario();
    apb(1, IDX_XFER_CTL, 8'h40); @(negedge mclk);
    chk("stop at zero tgt", 9'h000, {8'h00, cntStopAtZero});
    @(posedge mclk); cntWrapEvt <= 1; @(posedge mclk); cntWrapEvt <= 0;
    apb(0, IDX_STATUS, 0); chk("wrapped", 9'h001, {1'b0, rd});
    apb(1, IDX_STATUS, 8'h01); apb(0, IDX_STATUS, 0);
    chk("wrap cleared", 9'h000, {1'b0, rd});
    apb(1, IDX_MODE, 8'h00); @(negedge mclk);
    chk("stop at zero ini", 9'h001, {8'h00, cntStopAtZero});
    @(posedge mclk); cntWrapEvt <= 1; @(posedge mclk); cntWrapEvt <= 0;
    apb(1, IDX_XFER_CTL, 8'h00);
    @(posedge mclk); parityErrIn <= 1; @(posedge mclk); parityErrIn <= 0;
    apb(0, IDX_STATUS, 0); chk("no flags", 9'h000, {1'b0, rd});
    apb(1, IDX_XFER_CTL, 8'h20);
    @(posedge mclk); parityErrIn <= 1; @(posedge mclk); parityErrIn <= 0;
    apb(0, IDX_STATUS, 0); chk("parity flag", 9'h004, {1'b0, rd});
    apb(1, IDX_STATUS, 8'h04);
  endtask
  task automatic signalScenario();
    apb(1, IDX_MODE, 8'h01); apb(1, IDX_BUS_SIG, 8'hFF); @(negedge mclk);
    chk("target drive", 9'h0EE, {1'b0, oe});
    apb(1, IDX_BUS_SIG, 8'h00); @(negedge mclk);
    chk("release", 9'h000, {1'b0, oe});
    apb(1, IDX_MODE, 8'h00); apb(1, IDX_BUS_SIG, 8'hFF); @(negedge mclk);
    chk("init drive", 9'h01D, {1'b0, oe});
    apb(1, IDX_BUS_SIG, 8'h0C); @(negedge mclk);
    chk("atn held", 9'h01C, {1'b0, oe});
    apb(1, IDX_MODE, 8'h04); @(negedge mclk);
    chk("atn cleared", 9'h00C, {1'b0, oe});
    @(posedge mclk); busRstIn <= 0; repeat (4) @(posedge mclk); busRstIn <= 1;
    @(negedge mclk); chk("bus reset", 9'h000, {1'b0, oe});
    // live lines and phase compare at the next request
    @(posedge mclk); peerOe <= 8'hA5; repeat (4) @(posedge mclk);
    apb(0, IDX_BUS_SIG, 0); chk("live lines", 9'h0A5, {1'b0, rd});
    @(posedge mclk); peerOe <= 8'h84; repeat (4) @(posedge mclk); peerOe <= 8'h86;
    repeat (5) @(posedge mclk);
    apb(0, IDX_STATUS, 0); chk("phase mismatch", 9'h008, {1'b0, rd});
    apb(1, IDX_STATUS, 8'h08); apb(1, IDX_BUS_SIG, 8'h80);
    @(posedge mclk); peerOe <= 8'h84; repeat (4) @(posedge mclk); peerOe <= 8'h86;
    repeat (5) @(posedge mclk);
    apb(0, IDX_STATUS, 0); chk("phase match", 9'h000, {1'b0, rd});
    @(posedge mclk); peerOe <= 8'h00;
  endtask
  task automatic rateScenario();
    for (int c = 0; c < 8; c++) begin
      apb(1, IDX_RATE, {1'b0, 3'(c), 4'h0}); @(negedge mclk);
      chk("period", 9'(c + 2), {5'h00, per});
      chk("pulse async", (c < 2) ? 9'h003 : 9'h005, {6'h00, pw, asyncMode});
    end
    apb(1, IDX_RATE, 8'h38); @(negedge mclk);
    chk("offset", 9'h085, {asyncMode, ofs, per});
    apb(0, IDX_RATE, 0); chk("rate wo", 9'h000, {1'b0, rd});
  endtask
  task automatic timerScenario();
    int t0, lim, n;
    // no count while the selected party holds busy
    apb(1, IDX_XFER_CTL, 8'h1C); @(posedge mclk);
    bsyReturned <= 1; selSeqStart <= 1; selSeqActive <= 1;
    @(posedge mclk); selSeqStart <= 0; repeat (200) @(posedge mclk);
    apb(0, IDX_STATUS, 0); chk("timer stopped", 9'h000, {1'b0, rd});
    @(posedge mclk); bsyReturned <= 0; selSeqActive <= 0;
    for (int c = 0; c < 4; c++) begin
      lim = 256 >> c;
      apb(1, IDX_XFER_CTL, {3'h0, 2'(c), 3'h4}); apb(1, IDX_MODE, {6'h00, 1'(c), 1'b0});
      apb(1, IDX_BUS_SIG, 8'h08);
      @(posedge mclk); selSeqStart <= 1; selSeqActive <= 1; t0 = cyc;
      @(posedge mclk); selSeqStart <= 0; @(negedge mclk);
      chk("seq busy", 9'h001, {8'h00, oe[SIG_BSY]});
      n = 0;
      do begin
        apb(0, IDX_STATUS, 0);
        n++;
      end while (rd[ST_SELECT_TIMEOUT_FLAG] !== 1'b1 && n < 600);
      if (n >= 600) begin
        chk("timeout seen", 9'h001, 9'h000);
        finalReport();
      end
      chk("timeout late", 9'h001, {8'h00, (cyc - t0) >= lim * 4 - 2});
      chk("timeout early", 9'h001, {8'h00, (cyc - t0) <= lim * 4 + 16});
      @(negedge mclk); chk("sel kept", {8'h00, ~1'(c)}, {8'h00, oe[SIG_SEL]});
      @(posedge mclk); selSeqActive <= 0;
      apb(1, IDX_BUS_SIG, 8'h00); apb(1, IDX_STATUS, 8'h02);
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    sysRst <= 0;
    @(negedge mclk);
    chk("reset outputs", 9'h001, {oe, cntStopAtZero});
    chk("line level", 9'h000, {1'b0, drv});
    regScenario();
    dataScenario();
    statusScenario();
    signalScenario();
    rateScenario();
    timerScenario();
    finalReport();
  end
endmodule

// [bench/stc_bus_peer.sv]
// model: scsi bus peer, open-drain wired-or of device and peer drivers
module stc_bus_peer (
  // drivers of both parties, 1 = pull the line low
  input wire logic [7:0] devOe,
  input wire logic [7:0] peerOe,
  // resolved wire, active low, pulled up when released
  output logic [7:0] busLines
);
  timeunit 1ns;
  timeprecision 1ps;
  // terminator pull-up: a released line reads high, never the last value
  assign busLines = ~(devOe | peerOe);
endmodule

// [core/stc_ctrl.sv]
// module: transfer control, bus signal and rate register bank with APB access
module stc_ctrl #(
  parameter logic [stc_pkg::TICK_W-1:0] TICK_CYCLES = stc_pkg::TICK_W'(stc_pkg::MS_CYCLES)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register bus
  input wire stc_pkg::stc_apb_req_t apbReq,
  output stc_pkg::stc_apb_rsp_t apbRsp,
  // scsi control lines, active low on the wire
  input wire logic [7:0] busLinesIn,
  output logic [7:0] busLinesOut,
  output logic [7:0] busLinesOe,
  input wire logic busRstIn,
  // sequencer
  input wire logic selSeqStart,
  input wire logic selSeqActive,
  input wire logic bsyReturned,
  // transfer counter
  input wire logic cntWrapEvt,
  output logic cntStopAtZero,
  // data path
  input wire logic inboundValid,
  output logic fifoWrEn,
  input wire logic [7:0] fifoRdData,
  output logic [7:0] txData,
  output logic discardActive,
  output logic alignHandshake,
  input wire logic parityErrIn,
  // synchronous rate
  output logic [3:0] syncPeriodCycles,
  output logic [1:0] syncPulseCycles,
  output logic [3:0] syncOffset,
  output logic asyncMode
);
  import stc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  stc_state_t s_r;
  stc_state_t s_nxt;
  logic [9:0] regIdx;
  logic regHit;
  logic setupPh;
  logic accessPh;
  logic wrEn;
  logic [7:0] sense;
  logic busFree;
  logic busFreeEvt;
  logic reqRise;
  logic wrapAllowed;
  logic timerRun;
  logic timerExpired;
  logic sigWrite;

  // decode of the five mapped words
  function automatic logic isMapped(input logic [9:0] idx);
    isMapped = (idx == IDX_XFER_CTL) || (idx == IDX_BUS_SIG) || (idx == IDX_RATE) ||
               (idx == IDX_MODE) || (idx == IDX_STATUS);
  endfunction

  // mode word: bit0 target, bit1 timeout release, bit2 clear attention (never stored)
  // status word: bit0 wrapped, bit1 timeout, bit2 parity, bit3 phase mismatch;
  // status bits clear on a written one, but a hardware set in the same cycle wins
  // the rate word is write-only, so software must keep its own copy
  // read value of one register
  function automatic logic [7:0] readMux(input stc_state_t st, input logic [9:0] idx);
    readMux = REG_RESET;
    case (idx)
      IDX_XFER_CTL: readMux = st.xferCtl;
      IDX_BUS_SIG: readMux = st.lineSync;
      IDX_MODE: readMux = {6'h00, st.releaseEn, st.targetMode};
      IDX_STATUS: readMux = {4'h0, st.phaseMismatch, st.parityErr & st.xferCtl[XC_PARCHK],
                             st.selTimeout, st.wrapped};
      default: readMux = REG_RESET;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus decode and line sense
  // ----------------------------------------------------------------
  assign regIdx = apbReq.paddr[PADDR_W-1:2];
  assign regHit = isMapped(regIdx);
  assign setupPh = apbReq.psel && !apbReq.penable;
  assign accessPh = apbReq.psel && apbReq.penable;
  assign wrEn = accessPh && apbReq.pwrite && regHit;
  assign sense = s_r.lineSync;
  // bus free: neither BSY nor SEL asserted by anyone
  assign busFree = !sense[SIG_BSY] && !sense[SIG_SEL];
  assign busFreeEvt = busFree && !s_r.busFreePrev;
  assign reqRise = sense[SIG_REQ] && !s_r.reqPrev;
  assign wrapAllowed = s_r.xferCtl[XC_WRAPEN] && s_r.targetMode;
  // the count pauses while the selected party holds BSY
  assign timerRun = s_r.xferCtl[XC_TIMER] && selSeqActive && !bsyReturned;
  // write strobe of the line control word, used by the checks below
  assign sigWrite = wrEn && (regIdx == IDX_BUS_SIG);

  // ----------------------------------------------------------------
  // selection timer
  // ----------------------------------------------------------------
  stc_sel_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(selSeqStart),
    .run(timerRun),
    .limitMs(stc_timeout_ms(s_r.xferCtl[XC_TOSEL_HI:XC_TOSEL_LO])),
    .expired(timerExpired)
  );

  // ----------------------------------------------------------------
  // next state: bus writes first, hardware events after so sets win
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // two-stage synchronisers, lines inverted to asserted-high
    s_nxt.lineMeta = ~busLinesIn;
    s_nxt.lineSync = s_r.lineMeta;
    s_nxt.rstMeta = ~busRstIn;
    s_nxt.rstSync = s_r.rstMeta;
    s_nxt.reqPrev = sense[SIG_REQ];
    s_nxt.busFreePrev = busFree;
    s_nxt.alignPulse = 1'b0;
    // read data captured in setup so the access cycle answers from flops
    if (setupPh) begin
      s_nxt.prdata = readMux(s_r, regIdx);
    end
    if (wrEn) begin
      case (regIdx)
        IDX_XFER_CTL: begin
          s_nxt.xferCtl = apbReq.pwdata[7:0] & XC_WRITE_MASK;
          s_nxt.alignPulse = apbReq.pwdata[XC_ALIGN];
        end
        IDX_BUS_SIG: begin
          s_nxt.sigDrive[SIG_CD:SIG_MSG] = apbReq.pwdata[SIG_CD:SIG_MSG];
          s_nxt.sigDrive[SIG_SEL] = apbReq.pwdata[SIG_SEL];
          s_nxt.sigDrive[SIG_BSY] = apbReq.pwdata[SIG_BSY];
          s_nxt.sigDrive[SIG_REQ] = apbReq.pwdata[SIG_REQ];
          s_nxt.sigDrive[SIG_ACK] = apbReq.pwdata[SIG_ACK];
          // writing zero never drops attention; target writes are ignored
          if (!s_r.targetMode && apbReq.pwdata[SIG_ATN]) begin
            s_nxt.sigDrive[SIG_ATN] = 1'b1;
          end
        end
        IDX_RATE: s_nxt.rate = apbReq.pwdata[6:0];
        IDX_MODE: begin
          s_nxt.targetMode = apbReq.pwdata[MODE_TARGET];
          s_nxt.releaseEn = apbReq.pwdata[MODE_RELEASE];
          if (apbReq.pwdata[MODE_CLRATN]) begin
            s_nxt.sigDrive[SIG_ATN] = 1'b0;
          end
        end
        IDX_STATUS: begin
          // write one to clear
          if (apbReq.pwdata[ST_WRAP]) s_nxt.wrapped = 1'b0;
          if (apbReq.pwdata[ST_SELECT_TIMEOUT_FLAG]) s_nxt.selTimeout = 1'b0;
          if (apbReq.pwdata[ST_PERR]) s_nxt.parityErr = 1'b0;
          if (apbReq.pwdata[ST_PHASE]) s_nxt.phaseMismatch = 1'b0;
        end
        default: s_nxt.prdata = s_r.prdata;
      endcase
    end
    // bus free or bus reset wipes every written line control
    if (busFreeEvt || s_r.rstSync) begin
      s_nxt.sigDrive = REG_RESET;
    end
    // sequencer raises BSY at the start of a selection out
    if (selSeqStart) begin
      s_nxt.sigDrive[SIG_BSY] = 1'b1;
    end
    if (cntWrapEvt && wrapAllowed) begin
      s_nxt.wrapped = 1'b1;
    end
    if (parityErrIn && s_r.xferCtl[XC_PARCHK]) begin
      s_nxt.parityErr = 1'b1;
    end
    // timeout: flag always, drop SEL only when release is enabled
    if (timerExpired) begin
      s_nxt.selTimeout = 1'b1;
      if (s_r.releaseEn) begin
        s_nxt.sigDrive[SIG_SEL] = 1'b0;
      end
    end
    // initiator compares the bus phase with the expected one at each REQ
    if (!s_r.targetMode && reqRise &&
        (sense[SIG_CD:SIG_MSG] != s_r.sigDrive[SIG_CD:SIG_MSG])) begin
      s_nxt.phaseMismatch = 1'b1;
    end
    // discard mode sends zeros instead of FIFO data
    s_nxt.txData = discardActive ? 8'h00 : fifoRdData;
  end

  // hard reset clears everything, including line controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read data comes from flops, so no wait state is ever needed
  // zero-wait slave; unmapped words answer with an error
  assign apbRsp.prdata = {24'h000000, s_r.prdata};
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = accessPh && !regHit;

  // open-drain style: pull low while enabled
  assign busLinesOut = 8'h00;
  assign busLinesOe[SIG_CD] = s_r.targetMode && s_r.sigDrive[SIG_CD];
  assign busLinesOe[SIG_IO] = s_r.targetMode && s_r.sigDrive[SIG_IO];
  assign busLinesOe[SIG_MSG] = s_r.targetMode && s_r.sigDrive[SIG_MSG];
  assign busLinesOe[SIG_ATN] = !s_r.targetMode && s_r.sigDrive[SIG_ATN];
  assign busLinesOe[SIG_SEL] = s_r.sigDrive[SIG_SEL];
  assign busLinesOe[SIG_BSY] = s_r.sigDrive[SIG_BSY];
  assign busLinesOe[SIG_REQ] = s_r.targetMode && s_r.sigDrive[SIG_REQ];
  assign busLinesOe[SIG_ACK] = !s_r.targetMode && s_r.sigDrive[SIG_ACK];

  // discard ignores FIFO full, so inbound bytes are simply not written
  assign discardActive = s_r.xferCtl[XC_DISCARD] && !s_r.targetMode;
  assign fifoWrEn = inboundValid && !discardActive;
  assign txData = s_r.txData;
  assign cntStopAtZero = !wrapAllowed;
  assign alignHandshake = s_r.alignPulse;

  // period and pulse width in core clocks
  assign syncPeriodCycles = {1'b0, s_r.rate[RATE_PER_HI:RATE_PER_LO]} + SYNC_PERIOD_BASE;
  assign syncPulseCycles = (s_r.rate[RATE_PER_HI:RATE_PER_LO] < 3'h2) ?
                           SYNC_PW_SHORT : SYNC_PW_LONG;
  assign syncOffset = s_r.rate[RATE_OFS_HI:0];
  // offsets above eight are software's fault and are passed through as written
  assign asyncMode = (s_r.rate[RATE_OFS_HI:0] == 4'h0);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_discard_zero_out: assert property (discardActive |=> txData == 8'h00)
    else $error("discard mode sent a nonzero byte");
  a_discard_target_off: assert property (s_r.targetMode |->
    !discardActive && (fifoWrEn == inboundValid))
    else $error("discard mode active as target");
  a_wrap_flag_set: assert property (cntWrapEvt && wrapAllowed |=> s_r.wrapped)
    else $error("wrap did not set flag");
  a_wrap_init_stop: assert property (!s_r.targetMode |-> cntStopAtZero)
    else $error("counter wraps as initiator");
  a_perr_reads_zero: assert property (setupPh && regIdx == IDX_STATUS &&
                                      !s_r.xferCtl[XC_PARCHK] |=> !s_r.prdata[ST_PERR])
    else $error("parity error read while checking disabled");
  a_seltimeout_release: assert property (timerExpired && s_r.releaseEn |=>
                                         s_r.selTimeout && !busLinesOe[SIG_SEL])
    else $error("timeout did not release SEL");
  a_sel_kept_hold: assert property (timerExpired && !s_r.releaseEn && !wrEn && !busFreeEvt &&
                                    !s_r.rstSync |=> $stable(s_r.sigDrive[SIG_SEL]))
    else $error("SEL dropped without release enable");
  a_busfree_clear: assert property (busFreeEvt && !selSeqStart |=> s_r.sigDrive == 8'h00)
    else $error("bus free left line controls set");
  a_req_init_off: assert property (!s_r.targetMode |-> !busLinesOe[SIG_REQ] &&
                                   !busLinesOe[SIG_CD])
    else $error("REQ or phase driven as initiator");
  a_ack_target_off: assert property (s_r.targetMode |-> !busLinesOe[SIG_ACK] &&
                                     !busLinesOe[SIG_ATN])
    else $error("ACK or ATN driven as target");
  a_phase_check: assert property (!s_r.targetMode && reqRise &&
                                  sense[SIG_CD:SIG_MSG] != s_r.sigDrive[SIG_CD:SIG_MSG]
                                  |=> s_r.phaseMismatch)
    else $error("phase mismatch not flagged");
  a_bsy_seq_set: assert property (selSeqStart |=> s_r.sigDrive[SIG_BSY])
    else $error("sequence start did not raise BSY");
  a_align_one_pulse: assert property (alignHandshake |=> !alignHandshake)
    else $error("align handshake longer than one cycle");
  // write and bus reset effects on the line controls, rate word and align strobe; parity and wrap flag gating
  a_sel_write_drive: assert property (sigWrite && !timerExpired && !busFreeEvt &&
    !s_r.rstSync |=> busLinesOe[SIG_SEL] == $past(apbReq.pwdata[SIG_SEL]))
    else $error("SEL drive did not follow the write");
  a_bsy_write_drive: assert property (sigWrite && !selSeqStart && !busFreeEvt &&
    !s_r.rstSync |=> busLinesOe[SIG_BSY] == $past(apbReq.pwdata[SIG_BSY]))
    else $error("BSY drive did not follow the write");
  a_atn_write_hold: assert property (sigWrite && s_r.sigDrive[SIG_ATN] && !busFreeEvt &&
    !s_r.rstSync |=> s_r.sigDrive[SIG_ATN])
    else $error("writing the line word dropped ATN");
  a_atn_target_keep: assert property (sigWrite && s_r.targetMode &&
    !s_r.sigDrive[SIG_ATN] |=> !s_r.sigDrive[SIG_ATN])
    else $error("ATN set by a write as target");
  a_busrst_clear: assert property (s_r.rstSync && !selSeqStart |=>
    s_r.sigDrive == 8'h00)
    else $error("bus reset left line controls set");
  a_rate_offset: assert property (wrEn && regIdx == IDX_RATE |=>
    syncOffset == $past(apbReq.pwdata[RATE_OFS_HI:0]))
    else $error("offset differs from the written value");
  a_async_zero: assert property (wrEn && regIdx == IDX_RATE &&
    apbReq.pwdata[RATE_OFS_HI:0] == 4'h0 |=> asyncMode)
    else $error("zero offset did not select async mode");
  a_align_on_write: assert property (wrEn && regIdx == IDX_XFER_CTL &&
    apbReq.pwdata[XC_ALIGN] |=> alignHandshake)
    else $error("align write gave no handshake");
  a_perr_gated: assert property (parityErrIn && !s_r.xferCtl[XC_PARCHK] &&
    !s_r.parityErr |=> !s_r.parityErr)
    else $error("parity error stored while checking disabled");
  a_wrap_init_keep: assert property (cntWrapEvt && !wrapAllowed &&
    !s_r.wrapped |=> !s_r.wrapped)
    else $error("wrap flagged while wrap not allowed");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  c_timeout_seen: cover property (timerExpired ##1 s_r.selTimeout);
  c_wrap_seen: cover property (cntWrapEvt && wrapAllowed);
  c_phase_mismatch: cover property (!s_r.phaseMismatch ##1 s_r.phaseMismatch);
  c_discard_run: cover property (discardActive && inboundValid);
  c_timeout_release: cover property (timerExpired && s_r.releaseEn);
endmodule

// [core/stc_pkg.sv]
// package: register map, field layout, timing and state types of the transfer/signal control bank
package stc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam int PADDR_W = 12;
  localparam logic [9:0] IDX_XFER_CTL = 10'h342;
  localparam logic [9:0] IDX_BUS_SIG = 10'h343;
  localparam logic [9:0] IDX_RATE = 10'h344;
  localparam logic [9:0] IDX_MODE = 10'h3F0;
  localparam logic [9:0] IDX_STATUS = 10'h3F1;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int XC_DISCARD = 7;
  localparam int XC_WRAPEN = 6;
  localparam int XC_PARCHK = 5;
  localparam int XC_TOSEL_HI = 4;
  localparam int XC_TOSEL_LO = 3;
  localparam int XC_TIMER = 2;
  localparam int XC_ALIGN = 1;
  localparam logic [7:0] XC_WRITE_MASK = 8'hFE;
  localparam int SIG_CD = 7;
  localparam int SIG_IO = 6;
  localparam int SIG_MSG = 5;
  localparam int SIG_ATN = 4;
  localparam int SIG_SEL = 3;
  localparam int SIG_BSY = 2;
  localparam int SIG_REQ = 1;
  localparam int SIG_ACK = 0;
  localparam int RATE_PER_HI = 6;
  localparam int RATE_PER_LO = 4;
  localparam int RATE_OFS_HI = 3;
  localparam int MODE_TARGET = 0;
  localparam int MODE_RELEASE = 1;
  localparam int MODE_CLRATN = 2;
  localparam int ST_WRAP = 0;
  localparam int ST_SELECT_TIMEOUT_FLAG = 1;
  localparam int ST_PERR = 2;
  localparam int ST_PHASE = 3;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 17;
  localparam logic [8:0] SEL_TO_MS_00 = 9'h100;
  localparam logic [8:0] SEL_TO_MS_01 = 9'h080;
  localparam logic [8:0] SEL_TO_MS_10 = 9'h040;
  localparam logic [8:0] SEL_TO_MS_11 = 9'h020;
  localparam logic [3:0] SYNC_PERIOD_BASE = 4'h2;
  localparam logic [1:0] SYNC_PW_SHORT = 2'h1;
  localparam logic [1:0] SYNC_PW_LONG = 2'h2;

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } stc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } stc_apb_rsp_t;

  typedef struct packed {
    logic [TICK_W-1:0] tickCnt;
    logic [8:0] msCnt;
    logic done;
    logic expired;
  } stc_timer_t;

  typedef struct packed {
    logic [7:0] xferCtl;
    logic [7:0] sigDrive;
    logic [6:0] rate;
    logic targetMode;
    logic releaseEn;
    logic wrapped;
    logic selTimeout;
    logic parityErr;
    logic phaseMismatch;
    logic [7:0] prdata;
    logic [7:0] lineMeta;
    logic [7:0] lineSync;
    logic rstMeta;
    logic rstSync;
    logic reqPrev;
    logic busFreePrev;
    logic alignPulse;
    logic [7:0] txData;
  } stc_state_t;

  // timeout code to limit in ms
  function automatic logic [8:0] stc_timeout_ms(input logic [1:0] code);
    case (code)
      2'h0: stc_timeout_ms = SEL_TO_MS_00;
      2'h1: stc_timeout_ms = SEL_TO_MS_01;
      2'h2: stc_timeout_ms = SEL_TO_MS_10;
      default: stc_timeout_ms = SEL_TO_MS_11;
    endcase
  endfunction

endpackage

// [core/stc_sel_timer.sv]
// module: selection timer, millisecond prescaler and limit compare
module stc_sel_timer #(
  parameter logic [stc_pkg::TICK_W-1:0] TICK_CYCLES = stc_pkg::TICK_W'(stc_pkg::MS_CYCLES)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic restart,
  input wire logic run,
  input wire logic [8:0] limitMs,
  // result
  output logic expired
);
  import stc_pkg::*;

  stc_timer_t s_r;
  stc_timer_t s_nxt;

  // count ms while running; a fresh sequence always starts from zero
  always_comb begin
    s_nxt = s_r;
    s_nxt.expired = 1'b0;
    if (restart) begin
      s_nxt.tickCnt = '0;
      s_nxt.msCnt = 9'h000;
      s_nxt.done = 1'b0;
    end else if (run && !s_r.done) begin
      if (s_r.tickCnt == TICK_CYCLES - 1'b1) begin
        s_nxt.tickCnt = '0;
        s_nxt.msCnt = s_r.msCnt + 9'h001;
      end else begin
        s_nxt.tickCnt = s_r.tickCnt + 1'b1;
      end
      // one pulse per sequence, never repeated
      if (s_r.msCnt >= limitMs) begin
        s_nxt.expired = 1'b1;
        s_nxt.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.expired;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_timer_limit: assert property (expired |-> $past(s_r.msCnt) >= $past(limitMs))
    else $error("selection timer expired below its limit");
endmodule
